// ### src/cobr_pkg.sv
// cobr_pkg: register map, field positions and reset values of the
// codec output and bypass control bank.
// assumes an AXI4-Lite slave with 32-bit data, one register per word.
package cobr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_CLICK_GUARD    = 8'h29;
    localparam logic [7:0] IDX_BYPASS_ROUTE   = 8'h2A;
    localparam logic [7:0] IDX_BYPASS_VOL_CH0 = 8'h2B;
    localparam logic [7:0] IDX_BYPASS_VOL_CH1 = 8'h2C;
    localparam logic [7:0] IDX_BIAS_SUPPLY    = 8'h2D;
    localparam logic [7:0] IDX_CONV_OUT       = 8'h2E;
    localparam logic [7:0] IDX_OUT0_ATTEN     = 8'h2F;
    localparam int         NUM_REGS           = 7;
    localparam int         ADDR_W             = 10;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_CLICK_GUARD = 8'h3F;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_CONV_OUT    = 8'h18;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int POS_HEADOUT1_GUARD = 5;
    localparam int POS_HEADOUT0_GUARD = 4;
    localparam int POS_BIAS1_ON       = 5;
    localparam int POS_BIAS0_ON       = 4;
    localparam int POS_BIAS1_LEVEL    = 1;
    localparam int POS_BIAS0_LEVEL    = 0;
    localparam int POS_CONV_POL       = 5;
    localparam int POS_CONV1_SILENCE  = 4;
    localparam int POS_CONV0_SILENCE  = 3;
    localparam int POS_CONV1_POWER    = 1;
    localparam int POS_CONV0_POWER    = 0;

    ////////////////////////////////////////////////////////////////////////
    // bypass route encodings
    localparam logic [1:0] ROUTE_NONE = 2'h0;
    localparam logic [1:0] ROUTE_CH0  = 2'h1;
    localparam logic [1:0] ROUTE_CH1  = 2'h2;
    localparam logic [1:0] ROUTE_BOTH = 2'h3;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // bypass volume step, thousandths of a dB per code
    localparam int ATTEN_STEP_MDB = 375;

endpackage

// ### src/cobr_decode.sv
// cobr_decode: maps an AXI byte address to a register slot.
// assumes word-aligned addresses; any other address is unmapped.
`timescale 1ns/1ps
module cobr_decode
(
    // address in
    input  wire logic [cobr_pkg::ADDR_W-1:0] addr,
    // slot out
    output logic      [2:0]                  slot,
    output logic                             hit
);

    // word index check against the bank window
    always_comb
    begin
        logic [7:0] idx;
        idx  = addr[cobr_pkg::ADDR_W-1:2];
        hit  = (addr[1:0] == 2'h0) && (idx >= cobr_pkg::IDX_CLICK_GUARD)
               && (idx <= cobr_pkg::IDX_OUT0_ATTEN);
        slot = 3'(idx - cobr_pkg::IDX_CLICK_GUARD);
    end

endmodule

// ### src/cobr_route.sv
// cobr_route: turns the bypass route code into per-channel enables.
// assumes the code is a stable register value.
`timescale 1ns/1ps
module cobr_route
(
    // route code
    input  wire logic [1:0] route_sel,
    // per-channel bypass enables
    output logic            ch0_on,
    output logic            ch1_on
);

    // 01 feeds channel 0, 10 channel 1, 11 both
    always_comb
    begin
        ch0_on = (route_sel == cobr_pkg::ROUTE_CH0) ||
                 (route_sel == cobr_pkg::ROUTE_BOTH);
        ch1_on = (route_sel == cobr_pkg::ROUTE_CH1) ||
                 (route_sel == cobr_pkg::ROUTE_BOTH);
    end

endmodule

// ### src/cobr_regs.sv
// cobr_regs: codec output, bias and bypass control register bank.
// assumes an AXI4-Lite master on aclk; outputs feed analog control lines.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps

module cobr_regs
(
    // clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // write address channel
    input  wire logic [cobr_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    // write data channel
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    // write response channel
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // read address channel
    input  wire logic [cobr_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    // read data channel
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // click guard disables
    output logic                              headout1_click_guard_off,
    output logic                              headout0_click_guard_off,
    output logic [3:0]                        amp_click_guard_off,
    // bypass route
    output logic [1:0]                        bypass_route_sel,
    output logic                              bypass_ch0_on,
    output logic                              bypass_ch1_on,
    output logic [7:0]                        bypass_vol_ch0,
    output logic [7:0]                        bypass_vol_ch1,
    // microphone bias
    output logic                              bias1_output_on,
    output logic                              bias0_output_on,
    output logic                              bias1_level_sel,
    output logic                              bias0_level_sel,
    // converter control
    output logic                              conv_polarity_invert,
    output logic                              conv1_silence,
    output logic                              conv0_silence,
    output logic                              conv1_power_on,
    output logic                              conv0_power_on,
    output logic [7:0]                        conv0_attenuation
);

    ////////////////////////////////////////////////////////////////////////
    // write channel state
    typedef enum logic [2:0]
    {
        COBR_WR_IDLE = 3'b001,
        COBR_WR_HOLD = 3'b010,
        COBR_WR_RESP = 3'b100
    } cobr_wr_e;

    cobr_wr_e                         wr_st_q, wr_st_d;
    logic                             aw_have_q, aw_have_d;
    logic                             w_have_q, w_have_d;
    logic [cobr_pkg::ADDR_W-1:0]      awaddr_q, awaddr_d;
    logic [7:0]                       wbyte_q, wbyte_d;
    logic                             wlane_q, wlane_d;
    logic [1:0]                       bresp_q, bresp_d;
    logic [7:0]                       regs_q [cobr_pkg::NUM_REGS];
    logic [7:0]                       regs_d [cobr_pkg::NUM_REGS];
    logic                             awready_q, awready_d;
    logic                             wready_q, wready_d;
    logic                             bvalid_q, bvalid_d;

    // read channel state
    logic                             rvalid_q, rvalid_d;
    logic [31:0]                      rdata_q, rdata_d;
    logic [1:0]                       rresp_q, rresp_d;
    logic                             arready_q, arready_d;

    // outputs registered
    logic                             ch0_on_c, ch1_on_c;
    logic                             ch0_on_q, ch1_on_q;

    // decode results
    logic [2:0]                       wslot, rslot;
    logic                             whit, rhit;

    ////////////////////////////////////////////////////////////////////////
    // bank slot of a register index, slot 0 is the first in the window
    function automatic int slot_of(input logic [7:0] idx);
        slot_of = int'(idx) - int'(cobr_pkg::IDX_CLICK_GUARD);
    endfunction

    // slots of the seven registers, kept in step with the index map
    localparam int SLOT_GUARD   = slot_of(cobr_pkg::IDX_CLICK_GUARD);
    localparam int SLOT_ROUTE   = slot_of(cobr_pkg::IDX_BYPASS_ROUTE);
    localparam int SLOT_VOL_CH0 = slot_of(cobr_pkg::IDX_BYPASS_VOL_CH0);
    localparam int SLOT_VOL_CH1 = slot_of(cobr_pkg::IDX_BYPASS_VOL_CH1);
    localparam int SLOT_BIAS    = slot_of(cobr_pkg::IDX_BIAS_SUPPLY);
    localparam int SLOT_CONV    = slot_of(cobr_pkg::IDX_CONV_OUT);
    localparam int SLOT_ATTEN   = slot_of(cobr_pkg::IDX_OUT0_ATTEN);

    ////////////////////////////////////////////////////////////////////////
    // address decoders
    cobr_decode u_wdec
    (
        .addr (awaddr_q),
        .slot (wslot),
        .hit  (whit)
    );

    cobr_decode u_rdec
    (
        .addr (s_axi_araddr),
        .slot (rslot),
        .hit  (rhit)
    );

    // route code to per-channel enables
    cobr_route u_route
    (
        .route_sel (regs_q[SLOT_ROUTE][1:0]),
        .ch0_on    (ch0_on_c),
        .ch1_on    (ch1_on_c)
    );

    // reset value of a slot
    function automatic logic [7:0] reset_of(input int slot);
        case (slot)
            SLOT_GUARD: reset_of = cobr_pkg::RST_CLICK_GUARD;
            SLOT_CONV:  reset_of = cobr_pkg::RST_CONV_OUT;
            default: reset_of = cobr_pkg::RST_ZERO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write path: address and data taken in either order, then response
    always_comb
    begin
        wr_st_d   = wr_st_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wbyte_d   = wbyte_q;
        wlane_d   = wlane_q;
        bresp_d   = bresp_q;
        regs_d    = regs_q;
        case (wr_st_q)
            COBR_WR_IDLE, COBR_WR_HOLD:
            begin
                if (s_axi_awvalid && !aw_have_q)
                begin
                    aw_have_d = 1'b1;
                    awaddr_d  = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_have_q)
                begin
                    w_have_d = 1'b1;
                    wbyte_d  = s_axi_wdata[7:0];
                    wlane_d  = s_axi_wstrb[0];
                end
                wr_st_d = (aw_have_d && w_have_d) ? COBR_WR_HOLD
                                                  : COBR_WR_IDLE;
                if (aw_have_q && w_have_q)
                begin
                    // full byte store, reserved bits kept as written
                    if (whit && wlane_q)
                        regs_d[wslot] = wbyte_q;
                    bresp_d   = whit ? cobr_pkg::RESP_OKAY
                                     : cobr_pkg::RESP_SLVERR;
                    aw_have_d = 1'b0;
                    w_have_d  = 1'b0;
                    wr_st_d   = COBR_WR_RESP;
                end
            end
            COBR_WR_RESP:
            begin
                if (s_axi_bready)
                    wr_st_d = COBR_WR_IDLE;
            end
            default:
            begin
                wr_st_d = COBR_WR_IDLE;
            end
        endcase
        // handshake lines leave flops, so they follow the next state
        awready_d = (wr_st_d != COBR_WR_RESP) && !aw_have_d;
        wready_d  = (wr_st_d != COBR_WR_RESP) && !w_have_d;
        bvalid_d  = (wr_st_d == COBR_WR_RESP);
    end

    // write path registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_st_q   <= COBR_WR_IDLE;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wbyte_q   <= 8'h00;
            wlane_q   <= 1'b0;
            bresp_q   <= cobr_pkg::RESP_OKAY;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            for (int i = 0; i < cobr_pkg::NUM_REGS; i++)
                regs_q[i] <= reset_of(i);
        end
        else
        begin
            wr_st_q   <= wr_st_d;
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awaddr_q  <= awaddr_d;
            wbyte_q   <= wbyte_d;
            wlane_q   <= wlane_d;
            bresp_q   <= bresp_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            regs_q    <= regs_d;
        end
    end

    // write handshake outputs straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    ////////////////////////////////////////////////////////////////////////
    // read path: one read at a time, answer one cycle after the address
    always_comb
    begin
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        arready_d = arready_q;
        if (rvalid_q)
        begin
            if (s_axi_rready)
            begin
                rvalid_d  = 1'b0;
                arready_d = 1'b1;
            end
        end
        else if (s_axi_arvalid && arready_q)
        begin
            rvalid_d  = 1'b1;
            arready_d = 1'b0;
            rdata_d   = rhit ? {24'h000000, regs_q[rslot]}
                             : 32'h00000000;
            rresp_d   = rhit ? cobr_pkg::RESP_OKAY
                             : cobr_pkg::RESP_SLVERR;
        end
    end

    // read path registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= cobr_pkg::RESP_OKAY;
            arready_q <= 1'b1;
        end
        else
        begin
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            arready_q <= arready_d;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    ////////////////////////////////////////////////////////////////////////
    // registered route enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ch0_on_q <= 1'b0;
            ch1_on_q <= 1'b0;
        end
        else
        begin
            ch0_on_q <= ch0_on_c;
            ch1_on_q <= ch1_on_c;
        end
    end

    // click guard disables for the two output stages and four amplifiers
    assign headout1_click_guard_off =
        regs_q[SLOT_GUARD][cobr_pkg::POS_HEADOUT1_GUARD];
    assign headout0_click_guard_off =
        regs_q[SLOT_GUARD][cobr_pkg::POS_HEADOUT0_GUARD];
    assign amp_click_guard_off      = regs_q[SLOT_GUARD][3:0];

    // bypass route, its enables one cycle behind the code, and volumes
    assign bypass_route_sel         = regs_q[SLOT_ROUTE][1:0];
    assign bypass_ch0_on            = ch0_on_q;
    assign bypass_ch1_on            = ch1_on_q;
    assign bypass_vol_ch0           = regs_q[SLOT_VOL_CH0];
    assign bypass_vol_ch1           = regs_q[SLOT_VOL_CH1];

    // microphone bias enables and level selects
    assign bias1_output_on =
        regs_q[SLOT_BIAS][cobr_pkg::POS_BIAS1_ON];
    assign bias0_output_on =
        regs_q[SLOT_BIAS][cobr_pkg::POS_BIAS0_ON];
    assign bias1_level_sel =
        regs_q[SLOT_BIAS][cobr_pkg::POS_BIAS1_LEVEL];
    assign bias0_level_sel =
        regs_q[SLOT_BIAS][cobr_pkg::POS_BIAS0_LEVEL];

    // converter polarity, silence and power, and output 0 attenuation
    assign conv_polarity_invert =
        regs_q[SLOT_CONV][cobr_pkg::POS_CONV_POL];
    assign conv1_silence =
        regs_q[SLOT_CONV][cobr_pkg::POS_CONV1_SILENCE];
    assign conv0_silence =
        regs_q[SLOT_CONV][cobr_pkg::POS_CONV0_SILENCE];
    assign conv1_power_on =
        regs_q[SLOT_CONV][cobr_pkg::POS_CONV1_POWER];
    assign conv0_power_on =
        regs_q[SLOT_CONV][cobr_pkg::POS_CONV0_POWER];
    assign conv0_attenuation        = regs_q[SLOT_ATTEN];

endmodule

// ### sim/cobr_regs_sva.sv
// cobr_regs_sva: handshake and output checks for the control bank.
// assumes it is bound to cobr_regs and sees only that module's ports.
`timescale 1ns/1ps
module cobr_regs_sva
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // control outputs
    input wire logic        headout1_click_guard_off,
    input wire logic        headout0_click_guard_off,
    input wire logic [3:0]  amp_click_guard_off,
    input wire logic [1:0]  bypass_route_sel,
    input wire logic        bypass_ch0_on,
    input wire logic        bypass_ch1_on,
    input wire logic [7:0]  bypass_vol_ch0,
    input wire logic [7:0]  bypass_vol_ch1,
    input wire logic        conv1_silence,
    input wire logic        conv0_silence,
    input wire logic [7:0]  conv0_attenuation
);
    // one clock domain for every property
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////
    // reset values on the outputs
    rst_vals_a: assert property (
        $rose(aresetn) |-> {headout1_click_guard_off,
        headout0_click_guard_off, amp_click_guard_off, conv1_silence,
        conv0_silence} == 8'hFF && bypass_route_sel == 2'h0
        && conv0_attenuation == 8'h00 && s_axi_arready)
        else $error("outputs wrong after reset");
    // route code decoded into channel enables one cycle later
    route_dec_a: assert property (
        $past(aresetn) |-> {bypass_ch1_on, bypass_ch0_on}
        == $past(bypass_route_sel))
        else $error("bypass enables do not follow route code");
    // volumes change only as a write completes
    vol_stable_a: assert property (
        $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(conv0_attenuation)
        && $stable(bypass_vol_ch0) && $stable(bypass_vol_ch1))
        else $error("volume changed without a write");
    // write answer two cycles after both halves are taken
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    // response stands until taken
    bvalid_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    // read answer the cycle after the address is taken
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    // read data stands until taken
    rvalid_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid[*1] ##0
        $stable(s_axi_rdata))
        else $error("read data dropped");
    // byte registers read with zero upper bits, one read at a time
    rd_upper_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
        else $error("read data upper bits or arready wrong");
    // main scenarios
    wr_cov: cover property (s_axi_bvalid && s_axi_bready);
    err_cov: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    both_cov: cover property (bypass_ch0_on && bypass_ch1_on);
endmodule

// ### sim/codec_output_bypass_regs_test.sv
// codec_output_bypass_regs_test: self-checking bench for cobr_regs.
// assumes cobr_pkg, cobr_regs and cobr_regs_sva are compiled first.
`timescale 1ns/1ps
`define CHK(nm, got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module codec_output_bypass_regs_test;
    // bench-driven inputs
    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic [9:0]  s_axi_awaddr  = 10'h000;
    logic [9:0]  s_axi_araddr  = 10'h000;
    logic [2:0]  s_axi_awprot  = 3'h0;
    logic [2:0]  s_axi_arprot  = 3'h0;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    // design outputs
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, headout1_click_guard_off;
    logic        headout0_click_guard_off, bypass_ch0_on, bypass_ch1_on;
    logic        bias1_output_on, bias0_output_on, bias1_level_sel;
    logic        bias0_level_sel, conv_polarity_invert, conv1_silence;
    logic        conv0_silence, conv1_power_on, conv0_power_on;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bypass_route_sel;
    logic [3:0]  amp_click_guard_off;
    logic [7:0]  bypass_vol_ch0, bypass_vol_ch1, conv0_attenuation;
    logic [31:0] s_axi_rdata;
    // bookkeeping
    int          fails    = 0;
    int          compares = 0;
    logic [7:0]  img [7];
    // output groups for compact comparison
    wire  [5:0]  o_guard = {headout1_click_guard_off,
                            headout0_click_guard_off, amp_click_guard_off};
    wire  [3:0]  o_route = {bypass_route_sel, bypass_ch1_on, bypass_ch0_on};
    wire  [3:0]  o_bias  = {bias1_output_on, bias0_output_on,
                            bias1_level_sel, bias0_level_sel};
    wire  [4:0]  o_conv  = {conv_polarity_invert, conv1_silence,
                            conv0_silence, conv1_power_on, conv0_power_on};
    // rows: response, register index, write data
    localparam logic [17:0] ROWS [16] = '{18'h02900, 18'h029C5, 18'h02A01,
        18'h02A02, 18'h02A03, 18'h02AFC, 18'h02BFF, 18'h02C80, 18'h02D21,
        18'h02DD2, 18'h02E27, 18'h02EDA, 18'h02FFF, 18'h02F01, 18'h23055,
        18'h228AA};

    // design under test
    cobr_regs DUT (.*);

    // 100 MHz clock
    always #5 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // expected register image after reset
    task automatic set_rst();
        img = '{cobr_pkg::RST_CLICK_GUARD, 8'h00, 8'h00, 8'h00, 8'h00,
                cobr_pkg::RST_CONV_OUT, 8'h00};
    endtask

    // one write, address and data offered together
    task automatic wr(input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er,
                      input int hold = 0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= (hold == 0);
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (hold > 0 && n == hold)
                s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            summarize();
        end
        else
            `CHK("bresp", s_axi_bresp, er)
    endtask

    // one read
    task automatic rd(input logic [9:0] a, input logic [31:0] ed,
                      input logic [1:0] er, input int hold = 0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= (hold == 0);
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (hold > 0 && n == hold)
                s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        s_axi_rready <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            summarize();
        end
        else
        begin
            `CHK("rdata", s_axi_rdata, ed)
            `CHK("rresp", s_axi_rresp, er)
        end
    endtask

    // read back every register, then compare every control output
    task automatic check_all();
        for (int i = 0; i < 7; i++)
            rd({cobr_pkg::IDX_CLICK_GUARD + 8'(i), 2'b00}, {24'h0, img[i]},
               cobr_pkg::RESP_OKAY);
        `CHK("guards", o_guard, img[0][5:0])
        `CHK("route", o_route, {2{img[1][1:0]}})
        `CHK("vol0", bypass_vol_ch0, img[2])
        `CHK("vol1", bypass_vol_ch1, img[3])
        `CHK("bias", o_bias, {img[4][5:4], img[4][1:0]})
        `CHK("conv", o_conv, {img[5][5:3], img[5][1:0]})
        `CHK("atten", conv0_attenuation, img[6])
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence: reset, table rows, refusals, reset in mid-run
    initial
    begin
        set_rst();
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        check_all();
        $display("reset test done");
        for (int i = 0; i < 16; i++)
        begin
            wr({ROWS[i][15:8], 2'b00}, ROWS[i][7:0], 4'hF, ROWS[i][17:16]);
            if (ROWS[i][17:16] == cobr_pkg::RESP_OKAY)
                img[ROWS[i][15:8] - 8'h29] = ROWS[i][7:0];
            check_all();
            $display("row %0d done", i);
        end
        // unaligned, strobe-off and unmapped accesses change nothing
        wr(10'h0BD, 8'h77, 4'hF, cobr_pkg::RESP_SLVERR);
        wr(10'h0BC, 8'h77, 4'h0, cobr_pkg::RESP_OKAY);
        rd(10'h0C0, 32'h0, cobr_pkg::RESP_SLVERR);
        check_all();
        $display("refusal test done");
        // answers held back by a late ready must keep standing
        wr(10'h0A8, 8'h03, 4'hF, cobr_pkg::RESP_OKAY, 4);
        img[1] = 8'h03;
        rd(10'h0A8, 32'h00000003, cobr_pkg::RESP_OKAY, 4);
        check_all();
        $display("late ready test done");
        // reset after registers were changed restores reset values
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        set_rst();
        check_all();
        $display("mid-run reset test done");
        summarize();
    end
endmodule

// checker on the design's ports
bind cobr_regs cobr_regs_sva u_sva (.*);
